/* File: crf_map.vh */
// Register map, field positions, vectors and command codes of the core
`ifndef CRF_MAP_VH
`define CRF_MAP_VH
// APB byte offsets
`define CRF_OFF_ACC 8'h00
`define CRF_OFF_IDX 8'h04
`define CRF_OFF_SP 8'h08
`define CRF_OFF_PC 8'h0c
`define CRF_OFF_FLAGS 8'h10
`define CRF_OFF_CMD 8'h14
`define CRF_OFF_STAT 8'h18
// Flag register bit positions
`define CRF_FV 7
`define CRF_FH 4
`define CRF_FI 3
`define CRF_FN 2
`define CRF_FZ 1
`define CRF_FC 0
`define CRF_FL_ONES 8'h60
`define CRF_FL_RST 8'h68
// Reset values and vectors
`define CRF_SP_RST 16'h00ff
`define CRF_SP_LOW 8'hff
`define CRF_VEC_RST 16'hfffe
`define CRF_VEC_SWI 16'hfffc
`define CRF_VEC_MON 16'hfefc
`define CRF_VEC_IRQ0 16'hfffa
`define CRF_VEC_IRQ1 16'hfff8
// Soft trap opcode value is arbitrary
`define CRF_OP_TRAP 8'h83
// Oscillator stabilisation after deep halt, in clock cycles
`define CRF_STAB_CYC 13'd4096
// Stack byte indices
`define CRF_B_PCL 3'd0
`define CRF_B_PCH 3'd1
`define CRF_B_X 3'd2
`define CRF_B_ACC 3'd3
`define CRF_B_CCR 3'd4
// Command register fields and status bits
`define CRF_CMD_OP 4:0
`define CRF_CMD_ARG 23:8
`define CRF_ST_BUSY 0
`define CRF_ST_HALT 1
`define CRF_ST_BRK 2
`define CRF_ST_IR 15:8
// Command codes
`define CRF_C_NOP 5'h00
`define CRF_C_LDA 5'h01
`define CRF_C_ADD 5'h02
`define CRF_C_ADC 5'h03
`define CRF_C_SUB 5'h04
`define CRF_C_AND 5'h05
`define CRF_C_ASL 5'h06
`define CRF_C_LDX 5'h07
`define CRF_C_LDH 5'h08
`define CRF_C_PSHA 5'h09
`define CRF_C_PULA 5'h0a
`define CRF_C_RSP 5'h0b
`define CRF_C_CLI 5'h0c
`define CRF_C_SEI 5'h0d
`define CRF_C_WAIT 5'h0e
`define CRF_C_STOP 5'h0f
`define CRF_C_SWI 5'h10
`define CRF_C_RTI 5'h11
`define CRF_C_JMP 5'h12
`define CRF_C_FETCH 5'h13
`endif

/* File: crf_core.v */
// Programmer-visible core registers, flags, stacking and halt/break sequencing
// What this block does
// - 8-bit working register feeds and receives ALU operations.
// - 16-bit index pair, high and low bytes separately loadable.
// - Any reset loads stack pointer with 00ff.
// - Stack low-byte reload sets low byte to ff, high byte kept.
// - Stack pointer decrements on push, increments on pull.
// - Fetch pointer advances per fetch; jumps and interrupts load it.
// - Reset loads fetch pointer from vector at fffe and ffff.
// - Flag register holds mask and five flags; bits 6 and 5 read one.
// - Overflow flag set on two's complement overflow, else cleared.
// - Nibble carry set on carry from bit 3 to 4 in adds.
// - Mask blocks interrupts; set after stacking, before vector fetch.
// - Interrupt entry does not stack the index high byte.
// - With mask clear, highest-priority pending request is served first.
// - Return from handler restores registers and mask from the stack.
// - Reset sets the mask; the mask-clear op and both halts clear it, and returns reload it from the stack.
// - Negative flag follows bit 7 of the result.
// - Zero flag set when result is 00.
// - Carry flag from bit-7 carry, subtract borrow, or shifts.
// - Idle halt clears mask, stops clock; interrupt wake keeps it clear.
// - Deep halt clears mask; clock restarts after stabilisation delay.
// - Break loads trap opcode and vector fffc, or fefc in monitor mode.
// - Break starts after current operation completes.
// - Return in break routine ends break once request is gone.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
`include "crf_map.vh"

module crf_core (
    input wire pclk,
    input wire presetn,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg [15:0] mem_addr,
    output reg [7:0] mem_wdata,
    output reg mem_we,
    output reg mem_re,
    input wire [7:0] mem_rdata,
    input wire [1:0] irq_req,
    input wire brk_req,
    input wire monitor_mode,
    output reg [7:0] instr_reg,
    output reg core_clk_en,
    output reg brk_active
);
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_PUSH = 7'h02;
    localparam [6:0] S_PULL = 7'h04;
    localparam [6:0] S_VEC = 7'h08;
    localparam [6:0] S_FET = 7'h10;
    localparam [6:0] S_HALT = 7'h20;
    localparam [6:0] S_STAB = 7'h40;

    reg [1:0] irq_m_r, irq_s_r;
    reg brk_m_r, brk_s_r, mon_m_r, mon_s_r;
    reg [6:0] st_r;
    reg [7:0] acc_r, fl_r;
    reg [15:0] idx_r, sp_r, pc_r, vec_r, cmd_arg_r;
    reg [1:0] ph_r;
    reg [2:0] bi_r, be_r;
    reg ent_r, stop_r, cmd_pend_r;
    reg [4:0] cmd_op_r;
    reg [12:0] stab_r;
    reg [7:0] alu_res, alu_fl, pbyte;
    reg [31:0] rd_w;
    reg err_w;

    // Flag register view with the two fixed ones
    // fixed ones
    wire [7:0] ccr_w = fl_r | `CRF_FL_ONES;
    wire [7:0] m_w = cmd_arg_r[7:0];
    wire cin_w = (cmd_op_r == `CRF_C_ADC) & fl_r[`CRF_FC];
    wire [8:0] add9 = {1'b0, acc_r} + {1'b0, m_w} + {8'h00, cin_w};
    wire [4:0] nib = {1'b0, acc_r[3:0]} + {1'b0, m_w[3:0]} + {4'h0, cin_w};
    wire [8:0] sub9 = {1'b0, acc_r} - {1'b0, m_w};
    wire apb_acc = psel & penable & pready & ~pslverr;
    wire apb_wr = apb_acc & pwrite;
    wire brk_pend = brk_s_r & ~brk_active;
    wire irq_pend = (|irq_s_r) & ~fl_r[`CRF_FI];
    wire busy_w = (st_r != S_IDLE) | cmd_pend_r;

    // Pin inputs pass two flops; only the second stage is read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_m_r <= 2'h0;
            irq_s_r <= 2'h0;
            brk_m_r <= 1'b0;
            brk_s_r <= 1'b0;
            mon_m_r <= 1'b0;
            mon_s_r <= 1'b0;
        end else begin
            irq_m_r <= irq_req;
            irq_s_r <= irq_m_r;
            brk_m_r <= brk_req;
            brk_s_r <= brk_m_r;
            mon_m_r <= monitor_mode;
            mon_s_r <= mon_m_r;
        end
    end

    // ALU result and flags for the pending command
    always @* begin
        alu_res = acc_r;
        alu_fl = fl_r;
        case (cmd_op_r)
            `CRF_C_ADD, `CRF_C_ADC: begin
                alu_res = add9[7:0];
                alu_fl[`CRF_FH] = nib[4];
                alu_fl[`CRF_FC] = add9[8];
                alu_fl[`CRF_FV] = (acc_r[7] == m_w[7]) && (add9[7] != acc_r[7]);
            end
            `CRF_C_SUB: begin
                alu_res = sub9[7:0];
                alu_fl[`CRF_FC] = sub9[8];
                alu_fl[`CRF_FV] = (acc_r[7] != m_w[7]) && (sub9[7] != acc_r[7]);
            end
            `CRF_C_AND: begin
                alu_res = acc_r & m_w;
                alu_fl[`CRF_FV] = 1'b0;
            end
            `CRF_C_ASL: begin
                alu_res = {acc_r[6:0], 1'b0};
                alu_fl[`CRF_FC] = acc_r[7];
                alu_fl[`CRF_FV] = acc_r[7] ^ acc_r[6];
            end
            `CRF_C_LDA: begin
                alu_res = m_w;
                alu_fl[`CRF_FV] = 1'b0;
            end
            default: begin
                alu_res = acc_r;
            end
        endcase
        alu_fl[`CRF_FN] = alu_res[7];
        alu_fl[`CRF_FZ] = (alu_res == 8'h00);
    end

    // Byte to push for the current stack index
    always @* begin
        case (bi_r)
            `CRF_B_PCL: pbyte = pc_r[7:0];
            `CRF_B_PCH: pbyte = pc_r[15:8];
            // only the low index byte is stacked
            `CRF_B_X: pbyte = idx_r[7:0];
            `CRF_B_ACC: pbyte = acc_r;
            default: pbyte = ccr_w;
        endcase
    end

    // Read decode and refusal check, evaluated in the setup cycle
    always @* begin
        rd_w = 32'h0000_0000;
        err_w = 1'b0;
        if (paddr == `CRF_OFF_ACC) begin
            rd_w[7:0] = acc_r;
            err_w = pwrite & (st_r != S_IDLE);
        end else if (paddr == `CRF_OFF_IDX) begin
            rd_w[15:0] = idx_r;
            err_w = pwrite & (st_r != S_IDLE);
        end else if (paddr == `CRF_OFF_SP) begin
            rd_w[15:0] = sp_r;
            err_w = pwrite & (st_r != S_IDLE);
        end else if (paddr == `CRF_OFF_PC) begin
            rd_w[15:0] = pc_r;
            err_w = pwrite & (st_r != S_IDLE);
        end else if (paddr == `CRF_OFF_FLAGS) begin
            rd_w[7:0] = ccr_w;
            err_w = pwrite & (st_r != S_IDLE);
        end else if (paddr == `CRF_OFF_CMD) begin
            rd_w[4:0] = cmd_op_r;
            rd_w[23:8] = cmd_arg_r;
            err_w = pwrite & cmd_pend_r;
        end else if (paddr == `CRF_OFF_STAT) begin
            rd_w[`CRF_ST_BUSY] = busy_w;
            rd_w[`CRF_ST_HALT] = (st_r == S_HALT) | (st_r == S_STAB);
            rd_w[`CRF_ST_BRK] = brk_active;
            rd_w[`CRF_ST_IR] = instr_reg;
            err_w = pwrite;
        end else begin
            err_w = 1'b1;
        end
    end

    // APB slave: answer registered in setup, one access cycle always
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel & ~penable) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_w;
            pready <= 1'b1;
            pslverr <= err_w;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Core sequencer; it stays in idle while an APB transfer is open
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= S_VEC;
            acc_r <= 8'h00;
            idx_r <= 16'h0000;
            sp_r <= `CRF_SP_RST;
            pc_r <= 16'h0000;
            fl_r <= `CRF_FL_RST;
            vec_r <= `CRF_VEC_RST;
            ph_r <= 2'd0;
            bi_r <= 3'd0;
            be_r <= 3'd0;
            ent_r <= 1'b0;
            stop_r <= 1'b0;
            stab_r <= 13'd0;
            cmd_pend_r <= 1'b0;
            cmd_op_r <= `CRF_C_NOP;
            cmd_arg_r <= 16'h0000;
            instr_reg <= 8'h00;
            brk_active <= 1'b0;
            core_clk_en <= 1'b1;
            mem_addr <= 16'h0000;
            mem_wdata <= 8'h00;
            mem_we <= 1'b0;
            mem_re <= 1'b0;
        end else begin
            mem_we <= 1'b0;
            mem_re <= 1'b0;
            // Command write is taken whatever the state
            if (apb_wr && paddr == `CRF_OFF_CMD) begin
                cmd_pend_r <= 1'b1;
                cmd_op_r <= pwdata[`CRF_CMD_OP];
                cmd_arg_r <= pwdata[`CRF_CMD_ARG];
            end
            case (st_r)
                S_IDLE: begin
                    if (psel) begin
                        if (apb_wr && paddr == `CRF_OFF_ACC)
                            acc_r <= pwdata[7:0];
                        if (apb_wr && paddr == `CRF_OFF_IDX)
                            idx_r <= pwdata[15:0];
                        if (apb_wr && paddr == `CRF_OFF_SP)
                            sp_r <= pwdata[15:0];
                        if (apb_wr && paddr == `CRF_OFF_PC)
                            pc_r <= pwdata[15:0];
                        // software write may set mask, never clear it
                        if (apb_wr && paddr == `CRF_OFF_FLAGS)
                            fl_r <= (pwdata[7:0] & ~`CRF_FL_ONES)
                                | (fl_r & (8'h01 << `CRF_FI));
                    // break waits for the running operation
                    end else if (brk_pend) begin
                        instr_reg <= `CRF_OP_TRAP;
                        vec_r <= mon_s_r ? `CRF_VEC_MON : `CRF_VEC_SWI;
                        brk_active <= 1'b1;
                        st_r <= S_PUSH;
                        bi_r <= `CRF_B_PCL;
                        be_r <= `CRF_B_CCR;
                        ent_r <= 1'b1;
                    end else if (irq_pend) begin
                        vec_r <= irq_s_r[0] ? `CRF_VEC_IRQ0 : `CRF_VEC_IRQ1;
                        st_r <= S_PUSH;
                        bi_r <= `CRF_B_PCL;
                        be_r <= `CRF_B_CCR;
                        ent_r <= 1'b1;
                    end else if (cmd_pend_r) begin
                        cmd_pend_r <= 1'b0;
                        case (cmd_op_r)
                            `CRF_C_LDA, `CRF_C_ADD, `CRF_C_ADC, `CRF_C_SUB,
                            `CRF_C_AND, `CRF_C_ASL: begin
                                acc_r <= alu_res;
                                fl_r <= alu_fl;
                            end
                            `CRF_C_LDX: idx_r[7:0] <= m_w;
                            `CRF_C_LDH: idx_r[15:8] <= m_w;
                            `CRF_C_PSHA: begin
                                st_r <= S_PUSH;
                                bi_r <= `CRF_B_ACC;
                                be_r <= `CRF_B_ACC;
                                ent_r <= 1'b0;
                            end
                            `CRF_C_PULA: begin
                                st_r <= S_PULL;
                                ph_r <= 2'd0;
                                bi_r <= `CRF_B_ACC;
                                be_r <= `CRF_B_ACC;
                            end
                            `CRF_C_RSP: sp_r[7:0] <= `CRF_SP_LOW;
                            // this op clears the mask; both halts and stack pulls can also clear it
                            `CRF_C_CLI: fl_r[`CRF_FI] <= 1'b0;
                            `CRF_C_SEI: fl_r[`CRF_FI] <= 1'b1;
                            `CRF_C_WAIT, `CRF_C_STOP: begin
                                // halt clears mask and stops clock
                                fl_r[`CRF_FI] <= 1'b0;
                                stop_r <= (cmd_op_r == `CRF_C_STOP);
                                core_clk_en <= 1'b0;
                                st_r <= S_HALT;
                            end
                            `CRF_C_SWI: begin
                                instr_reg <= `CRF_OP_TRAP;
                                vec_r <= `CRF_VEC_SWI;
                                st_r <= S_PUSH;
                                bi_r <= `CRF_B_PCL;
                                be_r <= `CRF_B_CCR;
                                ent_r <= 1'b1;
                            end
                            `CRF_C_RTI: begin
                                st_r <= S_PULL;
                                ph_r <= 2'd0;
                                bi_r <= `CRF_B_CCR;
                                be_r <= `CRF_B_PCL;
                            end
                            `CRF_C_JMP: pc_r <= cmd_arg_r;
                            `CRF_C_FETCH: begin
                                st_r <= S_FET;
                                ph_r <= 2'd0;
                            end
                            default: begin
                                cmd_pend_r <= 1'b0;
                            end
                        endcase
                    end
                end
                S_PUSH: begin
                    mem_we <= 1'b1;
                    mem_addr <= sp_r;
                    mem_wdata <= pbyte;
                    sp_r <= sp_r - 16'h0001;
                    if (bi_r == be_r) begin
                        if (ent_r) begin
                            // mask set after stacking, before vector
                            fl_r[`CRF_FI] <= 1'b1;
                            st_r <= S_VEC;
                            ph_r <= 2'd0;
                            bi_r <= 3'd0;
                        end else begin
                            st_r <= S_IDLE;
                        end
                    end else begin
                        bi_r <= bi_r + 3'd1;
                    end
                end
                S_PULL: begin
                    if (ph_r == 2'd0) begin
                        sp_r <= sp_r + 16'h0001;
                        mem_addr <= sp_r + 16'h0001;
                        mem_re <= 1'b1;
                        ph_r <= 2'd1;
                    end else if (ph_r == 2'd1) begin
                        ph_r <= 2'd2;
                    end else begin
                        // registers and mask restored from stack
                        case (bi_r)
                            `CRF_B_CCR: fl_r <= mem_rdata & ~`CRF_FL_ONES;
                            `CRF_B_ACC: acc_r <= mem_rdata;
                            `CRF_B_X: idx_r[7:0] <= mem_rdata;
                            `CRF_B_PCH: pc_r[15:8] <= mem_rdata;
                            default: pc_r[7:0] <= mem_rdata;
                        endcase
                        ph_r <= 2'd0;
                        if (bi_r == be_r) begin
                            st_r <= S_IDLE;
                            // break ends only once request dropped
                            if (be_r == `CRF_B_PCL && !brk_s_r)
                                brk_active <= 1'b0;
                        end else begin
                            bi_r <= bi_r - 3'd1;
                        end
                    end
                end
                S_VEC: begin
                    if (ph_r == 2'd0) begin
                        mem_addr <= vec_r + {13'h0000, bi_r};
                        mem_re <= 1'b1;
                        ph_r <= 2'd1;
                    end else if (ph_r == 2'd1) begin
                        ph_r <= 2'd2;
                    end else begin
                        ph_r <= 2'd0;
                        // vector high byte first, then low byte
                        if (bi_r == 3'd0) begin
                            pc_r[15:8] <= mem_rdata;
                            bi_r <= 3'd1;
                        end else begin
                            pc_r[7:0] <= mem_rdata;
                            ent_r <= 1'b0;
                            st_r <= S_IDLE;
                        end
                    end
                end
                S_FET: begin
                    if (ph_r == 2'd0) begin
                        mem_addr <= pc_r;
                        mem_re <= 1'b1;
                        pc_r <= pc_r + 16'h0001;
                        ph_r <= 2'd1;
                    end else if (ph_r == 2'd1) begin
                        ph_r <= 2'd2;
                    end else begin
                        instr_reg <= mem_rdata;
                        ph_r <= 2'd0;
                        st_r <= S_IDLE;
                    end
                end
                S_HALT: begin
                    // Wake on either interrupt request line; mask stays clear so it is taken next
                    if (|irq_s_r) begin
                        if (stop_r) begin
                            stab_r <= `CRF_STAB_CYC;
                            st_r <= S_STAB;
                        end else begin
                            core_clk_en <= 1'b1;
                            st_r <= S_IDLE;
                        end
                    end
                end
                S_STAB: begin
                    // clock restarts after the full delay
                    if (stab_r == 13'd1) begin
                        core_clk_en <= 1'b1;
                        st_r <= S_IDLE;
                    end
                    stab_r <= stab_r - 13'd1;
                end
                default: begin
                    st_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule // crf_core

/* File: crf_core_asserts.sv */
// Concurrent checks on the core's APB, memory link, break and halt ports
`timescale 1ns/10ps
module crf_core_asserts (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [15:0] mem_addr,
    input wire mem_we,
    input wire mem_re,
    input wire [7:0] instr_reg,
    input wire core_clk_en,
    input wire brk_active
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Every setup gets exactly one access cycle
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // Unused upper read bits stay zero
    a_rdata_upper_zero: assert property (pready && !pwrite |-> prdata[31:24] == 8'h00)
        else $error("read data upper byte not zero");
    a_vec_first_read: assert property ($rose(presetn) |-> ##[0:3] (mem_re && mem_addr == 16'hfffe))
        else $error("reset vector not read first");
    // Pulls need a wait cycle, so reads never touch
    a_read_spaced: assert property (mem_re |=> !mem_re)
        else $error("memory reads back to back");
    a_push_descends: assert property (mem_we && $past(mem_we) |-> mem_addr == $past(mem_addr) - 16'h0001)
        else $error("stack writes not descending");
    a_trap_in_ir: assert property ($rose(brk_active) |-> ##[0:2] instr_reg == 8'h83)
        else $error("break without trap opcode");
    a_halt_holds: assert property ($fell(core_clk_en) |-> !core_clk_en [*4])
        else $error("core clock restarted at once");
endmodule // crf_core_asserts

/* File: crf_mem_model.sv */
// Byte-wide memory model answering the core's memory link
`timescale 1ns/10ps
module crf_mem_model (
    input wire pclk,
    input wire [15:0] mem_addr,
    input wire [7:0] mem_wdata,
    input wire mem_we,
    input wire mem_re,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:65535];
    // vector contents: reset 1234, trap 2000, monitor 3000, irq 4000/5000
    initial begin
        mem_rdata = 8'h00;
        mem[16'h1234] = 8'ha5;
        mem[16'hfffe] = 8'h12;
        mem[16'hffff] = 8'h34;
        mem[16'hfffc] = 8'h20;
        mem[16'hfffd] = 8'h00;
        mem[16'hfefc] = 8'h30;
        mem[16'hfefd] = 8'h00;
        mem[16'hfffa] = 8'h40;
        mem[16'hfffb] = 8'h00;
        mem[16'hfff8] = 8'h50;
        mem[16'hfff9] = 8'h00;
    end
    // Read data is good for one cycle only, then scrambled so stale use shows
    always @(posedge pclk) begin
        if (mem_we)
            mem[mem_addr] <= mem_wdata;
        mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
    end
endmodule // crf_mem_model

/* File: crf_tb.sv */
// Self-checking bench for the core registers through APB commands
`timescale 1ns/10ps
`include "crf_map.vh"
module testbench;
    logic pclk, presetn, psel, penable, pwrite, brk_req, monitor_mode, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, q;
    logic [1:0] irq_req;
    wire [31:0] prdata;
    wire [15:0] mem_addr;
    wire [7:0] mem_wdata, mem_rdata, instr_reg;
    wire pready, pslverr, mem_we, mem_re, core_clk_en, brk_active;
    int error_cnt, comparisons;
    crf_core dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata), .irq_req(irq_req),
        .brk_req(brk_req), .monitor_mode(monitor_mode), .instr_reg(instr_reg),
        .core_clk_en(core_clk_en), .brk_active(brk_active));
    crf_mem_model u_mem (.pclk(pclk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));
    task tally_and_finish;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; an idle edge always precedes setup
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (pready !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: no pready", $time);
            tally_and_finish;
        end
    endtask
    // Poll status until the core is idle, bounded
    task wait_idle;
        for (int i = 0; i < 2500; i++) begin
            apb(1'b0, 8'h18, 32'h0);
            if (q[0] === 1'b0) return;
        end
        error_cnt++;
        $display("CHECK FAILED at %0t: core stuck busy", $time);
        tally_and_finish;
    endtask
    task cmd(input logic [4:0] op, input logic [15:0] arg);
        apb(1'b1, 8'h14, {8'h00, arg, 3'b000, op});
        wait_idle;
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q & m, x);
    endtask
    task alu(input logic [4:0] op, input logic [7:0] b, input logic [7:0] ea,
             input logic [7:0] ef, input logic [7:0] fm);
        cmd(op, {8'h00, b});
        rdchk(8'h00, 32'hff, {24'h0, ea});
        rdchk(8'h10, {24'h0, fm}, {24'h0, ef & fm});
    endtask
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; irq_req = 2'b00; brk_req = 1'b0; monitor_mode = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        wait_idle;
        rdchk(8'h08, 32'hffff, 32'h00ff);
        rdchk(8'h10, 32'hff, 32'h68);
        rdchk(8'h0c, 32'hffff, 32'h1234);
        cmd(`CRF_C_FETCH, 16'h0);
        rdchk(8'h0c, 32'hffff, 32'h1235);
        rdchk(8'h18, 32'hff00, 32'ha500);
        alu(`CRF_C_LDA, 8'h7f, 8'h7f, 8'h68, 8'h0e);
        alu(`CRF_C_ADD, 8'h01, 8'h80, 8'hfc, 8'hff);
        alu(`CRF_C_ADD, 8'h80, 8'h00, 8'heb, 8'hff);
        alu(`CRF_C_SUB, 8'h01, 8'hff, 8'h6d, 8'hef);
        alu(`CRF_C_ADC, 8'h01, 8'h01, 8'h79, 8'hff);
        alu(`CRF_C_AND, 8'h0f, 8'h01, 8'h69, 8'hef);
        alu(`CRF_C_ASL, 8'h00, 8'h02, 8'h68, 8'hef);
        cmd(`CRF_C_LDH, 16'h00ab);
        cmd(`CRF_C_LDX, 16'h00cd);
        rdchk(8'h04, 32'hffff_ffff, 32'habcd);
        apb(1'b1, 8'h08, 32'h12a0);
        cmd(`CRF_C_PSHA, 16'h0);
        rdchk(8'h08, 32'hffff, 32'h129f);
        chk({24'h0, u_mem.mem[16'h12a0]}, 32'h02);
        alu(`CRF_C_LDA, 8'h00, 8'h00, 8'h00, 8'h00);
        alu(`CRF_C_PULA, 8'h00, 8'h02, 8'h00, 8'h00);
        rdchk(8'h08, 32'hffff, 32'h12a0);
        cmd(`CRF_C_RSP, 16'h0);
        rdchk(8'h08, 32'hffff, 32'h12ff);
        irq_req <= 2'b11;
        repeat (20) @(posedge pclk);
        rdchk(8'h0c, 32'hffff, 32'h1235);
        cmd(`CRF_C_CLI, 16'h0);
        // The entry starts at the first idle edge after the poll above saw idle
        wait_idle;
        rdchk(8'h0c, 32'hffff, 32'h4000);
        rdchk(8'h08, 32'hffff, 32'h12fa);
        rdchk(8'h10, 32'h08, 32'h08);
        irq_req <= 2'b00;
        cmd(`CRF_C_RTI, 16'h0);
        rdchk(8'h0c, 32'hffff, 32'h1235);
        rdchk(8'h10, 32'h08, 32'h00);
        // Idle halt then deep halt, both woken by request line 1, the lower-priority one
        for (int k = 0; k < 2; k++) begin
            cmd(`CRF_C_SEI, 16'h0);
            apb(1'b1, 8'h14, k ? 32'h0f : 32'h0e);
            rdchk(8'h10, 32'h08, 32'h00);
            irq_req <= 2'b10;
            wait_idle;
            wait_idle;
            rdchk(8'h0c, 32'hffff, 32'h5000);
            irq_req <= 2'b00;
            cmd(`CRF_C_RTI, 16'h0);
        end
        for (int m = 0; m < 2; m++) begin
            monitor_mode <= m[0];
            brk_req <= 1'b1;
            repeat (8) @(posedge pclk);
            brk_req <= 1'b0;
            wait_idle;
            rdchk(8'h0c, 32'hffff, m ? 32'h3000 : 32'h2000);
            rdchk(8'h18, 32'hff04, 32'h8304);
            cmd(`CRF_C_RTI, 16'h0);
            chk({31'h0, brk_active}, 32'h0);
        end
        apb(1'b0, 8'h1c, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, 8'h18, 32'h0);
        chk({31'h0, e}, 32'h1);
        tally_and_finish;
    end
endmodule // testbench
bind crf_core crf_core_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_addr(mem_addr), .mem_we(mem_we), .mem_re(mem_re),
    .instr_reg(instr_reg), .core_clk_en(core_clk_en), .brk_active(brk_active));
